//--- fsd_top.sv
// Purpose: FSK demodulator, post filter, slicer, bit clock recovery and sync word match
// Assumes: One clock; iq samples arrive with a demodulator clock strobe
// Notes: APB slave answers with zero wait states
`timescale 1ns/1ps
`default_nettype none

// Function
// (R1) Correlator mode filters both tones and compares correlator output levels.
// (R2) Second-order low-pass after the discriminator, coefficient from ten-bit field.
// (R3) Correlator bandwidth comes from a ten-bit setting field; the leak is fixed at one-eighth and the field sets only the input step.
// (R4) Correlator mode slices the filtered value at fixed zero.
// (R5) Bit PLL oversamples sliced data at 32 times the data rate.
// (R6) Bit PLL holds lock through two percent rate error.
// (R7) Select field 01 picks the correlator demodulator.
// (R8) Select field 00 picks the linear demodulator, same filter field.
// (R9) Linear mode: frequency discriminator, averager with envelope, slicer.
// (R10) Linear slicer output feeds the bit PLL.
// (R11) Enabled sync detection compares received bits with stored word, flags match.
// (R12) Match indicator drops itself nine recovered bit clocks later.
// (R13) Sync detection runs only in demod modes 2 and 3.
// (R14) Length field chooses 12, 16, 20 or 24 compared bits.
// (R15) Transmitter sends the sync word most significant bit first.
// (R16) Tolerance field accepts up to three mismatched bits.
// (R17) One bit shifts in per recovered clock, then match is evaluated.
module fsd_top #(
   parameter int ACC_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register bus
   input wire fsd_pkg::fsd_apb_req_t apb_req,
   output fsd_pkg::fsd_apb_rsp_t apb_rsp,
   // Baseband samples
   input wire fsd_pkg::fsd_iq_t iq,
   input wire logic demod_tick,
   input wire logic recovery_oversample_clock,
   // Host side
   output logic rx_data,
   output logic rx_bit_clk,
   output logic sync_match,
   output logic irq
);
   import fsd_pkg::*;

   initial begin
      if (ACC_W < 12 || ACC_W > 24) $error("ACC_W out of range");
   end

   // Registers
   logic [31:0] demod_r, sync_r, bw_r;
   logic [FSD_IRQ_W-1:0] stat_r, ien_r;
   logic [1:0] sel;
   logic [2:0] mode;
   logic [9:0] post_filter_bandwidth_setting, discriminator_bandwidth_setting;
   logic [1:0] slen, stol;
   logic [23:0] sword;
   assign sel = demod_r[FSD_SEL_LSB +: 2];
   assign mode = demod_r[FSD_MODE_LSB +: 3];
   assign post_filter_bandwidth_setting = demod_r[FSD_PBW_LSB +: 10];
   assign discriminator_bandwidth_setting = bw_r[FSD_DBW_LSB +: 10];
   assign slen = sync_r[FSD_SLEN_LSB +: 2];
   assign stol = sync_r[FSD_STOL_LSB +: 2];
   assign sword = sync_r[FSD_SWORD_LSB +: 24];

   // Write strobe in the access phase; events feeding the sticky status
   logic wr_en, match_ev, bit_ev;
   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;

   // Configuration writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         demod_r <= FSD_RST_DEMOD;
         sync_r <= FSD_RST_SYNC;
         bw_r <= FSD_RST_BW;
         ien_r <= '0;
      end else if (wr_en) begin
         case (apb_req.paddr)
            FSD_OFS_DEMOD: demod_r <= apb_req.pwdata;
            FSD_OFS_SYNC: sync_r <= apb_req.pwdata;
            FSD_OFS_BW: bw_r <= apb_req.pwdata;
            FSD_OFS_IEN: ien_r <= apb_req.pwdata[FSD_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Sticky status; a new event wins over a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= '0;
      end else begin
         for (int k = 0; k < FSD_IRQ_W; k++) begin
            if ((k == FSD_IRQ_MATCH && match_ev) || (k == FSD_IRQ_BIT && bit_ev)) begin
               stat_r[k] <= 1'b1;
            end else if (wr_en && apb_req.paddr == FSD_OFS_ICLR && apb_req.pwdata[k]) begin
               stat_r[k] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(stat_r & ien_r);

   // Read mux; unmapped addresses answer with an error
   logic [31:0] rdata;
   logic hit;
   always_comb begin
      rdata = '0;
      hit = 1'b1;
      case (apb_req.paddr)
         FSD_OFS_DEMOD: rdata = demod_r;
         FSD_OFS_SYNC: rdata = sync_r;
         FSD_OFS_BW: rdata = bw_r;
         FSD_OFS_STAT: rdata[FSD_IRQ_W-1:0] = stat_r;
         FSD_OFS_IEN: rdata[FSD_IRQ_W-1:0] = ien_r;
         FSD_OFS_ICLR: rdata = '0;
         FSD_OFS_LIVE: rdata = {29'h0, sync_match, rx_bit_clk, rx_data};
         default: hit = 1'b0;
      endcase
   end
   // Read data captured in the setup phase so it stands through the access phase
   logic [31:0] prdata_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= '0;
      end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
         prdata_r <= rdata;
      end
   end
   // Whole answer built in one place: zero wait states, error on unmapped access
   assign apb_rsp = '{pready: 1'b1,
                      pslverr: apb_req.psel && apb_req.penable && !hit,
                      prdata: prdata_r};

   // Instantaneous frequency sign from iq phase rotation
   fsd_iq_t iq_d_r;
   logic rot;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) iq_d_r <= '0;
      else if (demod_tick) iq_d_r <= iq;
   end
   assign rot = (iq.i ^ iq_d_r.q) ? 1'b1 : 1'b0; // High for positive rotation

   // Tone correlators: leaky energy per tone with a fixed one-eighth leak, input step sized by the bandwidth field
   logic signed [ACC_W-1:0] corr_hi_r, corr_lo_r, lin_r, disc;
   logic signed [ACC_W-1:0] step;
   assign step = ACC_W'(signed'({1'b0, discriminator_bandwidth_setting}));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         corr_hi_r <= '0;
         corr_lo_r <= '0;
      end else if (demod_tick) begin
         corr_hi_r <= corr_hi_r - (corr_hi_r >>> 3) + (rot ? step : '0); // R1 R3
         corr_lo_r <= corr_lo_r - (corr_lo_r >>> 3) + (rot ? '0 : step); // R1 R3
      end
   end

   // Linear discriminator with averaging and envelope tracking
   logic signed [ACC_W-1:0] env_hi_r, env_lo_r, avg_r;
   logic signed [ACC_W-1:0] lin_in;
   assign lin_in = rot ? ACC_W'(signed'(17'sd1024)) : -ACC_W'(signed'(17'sd1024));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lin_r <= '0;
         env_hi_r <= '0;
         env_lo_r <= '0;
      end else if (demod_tick) begin
         lin_r <= lin_r + ((lin_in - lin_r) >>> 2); // R9
         env_hi_r <= (lin_r > env_hi_r) ? lin_r : env_hi_r - (env_hi_r >>> 6); // R9
         env_lo_r <= (lin_r < env_lo_r) ? lin_r : env_lo_r - (env_lo_r >>> 6); // R9
      end
   end

   // Demodulator select
   always_comb begin
      case (sel)
         FSD_SEL_CORR: disc = corr_hi_r - corr_lo_r; // R7 R1
         default: disc = lin_r - ((env_hi_r + env_lo_r) >>> 1); // R8 R9
      endcase
   end

   // Second-order post filter: two cascaded one-pole sections
   logic signed [ACC_W+10:0] s1_r, s2_r;
   logic signed [ACC_W+10:0] k;
   assign k = (ACC_W+11)'(signed'({1'b0, post_filter_bandwidth_setting}));
   // Error times coefficient needs eleven more bits than the state, or it wraps
   logic signed [ACC_W+21:0] e1, e2;
   assign e1 = ((((ACC_W+22)'(disc)) <<< 10) - (ACC_W+22)'(s1_r)) * (ACC_W+22)'(k); // R2
   assign e2 = ((ACC_W+22)'(s1_r) - (ACC_W+22)'(s2_r)) * (ACC_W+22)'(k); // R2
   // Both sections advance on the demodulator strobe only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
      end else if (demod_tick) begin
         s1_r <= s1_r + (ACC_W+11)'(e1 >>> 10); // R2 R8
         s2_r <= s2_r + (ACC_W+11)'(e2 >>> 10); // R2
      end
   end

   // Slicer: threshold zero on filter output
   logic sliced;
   assign sliced = !s2_r[ACC_W+10]; // R4 R10

   // Bit PLL: 5-bit phase, nudged by one step at each data edge
   logic [4:0] phase_r;
   logic sl_d_r, bit_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= '0;
         sl_d_r <= 1'b0;
         bit_r <= 1'b0;
      end else if (recovery_oversample_clock) begin
         sl_d_r <= sliced; // R5 R10
         if (sliced != sl_d_r) begin
            // Edge expected at phase 0; a single step per edge tracks 2% drift
            phase_r <= phase_r + (phase_r[4] ? 5'h2 : 5'h0); // R6
         end else begin
            phase_r <= phase_r + 5'h1; // R5
         end
         if (phase_r == 5'(FSD_OVERSAMPLE/2)) bit_r <= sliced;
      end
   end
   assign bit_ev = recovery_oversample_clock && phase_r == 5'(FSD_OVERSAMPLE/2);

   // Outputs toward the host
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data <= 1'b0;
         rx_bit_clk <= 1'b0;
      end else begin
         rx_data <= bit_r;
         rx_bit_clk <= !phase_r[4];
      end
   end

   // Sync word shift register, newest bit at bit 0 so the first sent bit is oldest
   logic [23:0] shreg_r;
   logic [4:0] nbits;
   logic [23:0] lenmask, diff;
   logic [4:0] errs;
   logic sync_on;
   assign nbits = 5'd12 + {1'b0, slen, 2'b00}; // R14
   assign lenmask = 24'hff_ffff >> (5'd24 - nbits);
   assign diff = (shreg_r ^ sword) & lenmask; // R15
   assign sync_on = mode == FSD_MODE_SYNC2 || mode == FSD_MODE_SYNC3; // R13
   always_comb begin
      errs = '0;
      for (int b = 0; b < 24; b++) errs = errs + 5'(diff[b]);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) shreg_r <= '0;
      else if (bit_ev) shreg_r <= {shreg_r[22:0], sliced}; // R17
   end

   // Match evaluated one cycle after each shift
   logic eval_r;
   logic [3:0] hold_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) eval_r <= 1'b0;
      else eval_r <= bit_ev;
   end
   assign match_ev = eval_r && sync_on && errs <= {3'h0, stol}; // R11 R16 R17

   // Indicator held for nine recovered bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_r <= '0;
      end else if (match_ev && hold_r == '0) begin
         hold_r <= 4'(FSD_IND_BITS); // R11
      end else if (bit_ev && hold_r != '0) begin
         hold_r <= hold_r - 4'h1; // R12
      end
   end
   assign sync_match = hold_r != '0;

   // Checks
   match_needs_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(sync_match) |-> $past(sync_on)) else $error("match outside sync mode"); // R13
   ind_nine_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(sync_match) |-> hold_r == 4'(FSD_IND_BITS)) else $error("hold not nine"); // R12
   ind_drops_a: assert property (@(posedge clk) disable iff (!rst_n)
      (hold_r == 4'h1 && bit_ev) |=> !sync_match) else $error("indicator stuck"); // R12
   tol_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
      match_ev |-> errs <= 5'd3) else $error("too many errors"); // R16
   shift_one_a: assert property (@(posedge clk) disable iff (!rst_n)
      bit_ev |=> shreg_r[0] == $past(sliced)) else $error("shift wrong"); // R17
   slice_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s2_r > 0) |-> sliced) else $error("slicer threshold"); // R4
   len_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      nbits >= 5'd12 && nbits <= 5'd24) else $error("length range"); // R14
   // A match event must leave its status bit set even under a clear
   irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      match_ev |=> stat_r[FSD_IRQ_MATCH]) else $error("match status lost"); // R11
   // A clear of the bit status with no new bit event empties it
   clr_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && apb_req.paddr == FSD_OFS_ICLR && apb_req.pwdata[FSD_IRQ_BIT] && !bit_ev)
      |=> !stat_r[FSD_IRQ_BIT]) else $error("bit status not cleared"); // R11
   // The recovered bit reaches the host pin two edges after its sample
   data_path_a: assert property (@(posedge clk) disable iff (!rst_n)
      bit_ev |-> ##2 rx_data == $past(sliced, 2)) else $error("data path"); // R10
   // An enabled, set match status bit always raises the interrupt
   irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      (stat_r[FSD_IRQ_MATCH] && ien_r[FSD_IRQ_MATCH]) |-> irq) else $error("irq missing"); // R11
   // Tolerated match with at least one wrong bit
   cv_tol_c: cover property (@(posedge clk) disable iff (!rst_n) match_ev && errs != '0);
   cv_match_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(sync_match));
   cv_corr_c: cover property (@(posedge clk) disable iff (!rst_n) sel == FSD_SEL_CORR && bit_ev);
   cv_lin_c: cover property (@(posedge clk) disable iff (!rst_n) sel == FSD_SEL_LINEAR && bit_ev);
endmodule : fsd_top

`default_nettype wire

//--- fsd_pkg.sv
// Purpose: Shared constants and types for the FSK demodulator and sync detector
// Assumes: 100 MHz system clock, APB register access
// Notes: Register byte offsets are word aligned
package fsd_pkg;
   // Register byte offsets
   localparam logic [7:0] FSD_OFS_DEMOD = 8'h00;
   localparam logic [7:0] FSD_OFS_SYNC = 8'h04;
   localparam logic [7:0] FSD_OFS_BW = 8'h08;
   localparam logic [7:0] FSD_OFS_STAT = 8'h0c;
   localparam logic [7:0] FSD_OFS_IEN = 8'h10;
   localparam logic [7:0] FSD_OFS_ICLR = 8'h14;
   localparam logic [7:0] FSD_OFS_LIVE = 8'h18;
   // Demodulator setup field positions
   localparam int FSD_SEL_LSB = 4;
   localparam int FSD_MODE_LSB = 23;
   localparam int FSD_PBW_LSB = 6;
   // Sync register field positions
   localparam int FSD_SLEN_LSB = 4;
   localparam int FSD_STOL_LSB = 6;
   localparam int FSD_SWORD_LSB = 8;
   // Discriminator bandwidth field position in bandwidth register
   localparam int FSD_DBW_LSB = 4;
   // Demodulator select codes
   localparam logic [1:0] FSD_SEL_LINEAR = 2'h0;
   localparam logic [1:0] FSD_SEL_CORR = 2'h1;
   // Demod modes with sync detection
   localparam logic [2:0] FSD_MODE_SYNC2 = 3'h2;
   localparam logic [2:0] FSD_MODE_SYNC3 = 3'h3;
   // Oversampling ratio and indicator hold length
   localparam int FSD_OVERSAMPLE = 32;
   localparam int FSD_IND_BITS = 9;
   // Reset values
   localparam logic [31:0] FSD_RST_DEMOD = 32'h0000_0000;
   localparam logic [31:0] FSD_RST_SYNC = 32'h0000_0000;
   localparam logic [31:0] FSD_RST_BW = 32'h0000_0000;
   // Interrupt status bits
   localparam int FSD_IRQ_MATCH = 0;
   localparam int FSD_IRQ_BIT = 1;
   localparam int FSD_IRQ_W = 2;

   // APB request and answer carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } fsd_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fsd_apb_rsp_t;

   // Limited quadrature input sample
   typedef struct packed {
      logic i;
      logic q;
   } fsd_iq_t;
endpackage : fsd_pkg

//--- fsd_dummy_unused.sv
`timescale 1ns/1ps

//--- fsd_host_model.sv
// Purpose: Host side watcher of the recovered bit clock and sync indicator
// Assumes: Indicator and bit clock are registered levels on clk
// Notes: Counts indicator pulses and bit clock rises while the indicator stands
`timescale 1ns/1ps
`default_nettype none
module fsd_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Receiver outputs
   input wire logic rx_bit_clk,
   input wire logic sync_match,
   // Observations
   output var int match_count,
   output var int hold_clks
);
   logic bclk_q;
   logic sm_q;
   int run;
   // Pulse counting and indicator width in recovered clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_q <= 1'b0;
         sm_q <= 1'b0;
         run <= 0;
         match_count <= 0;
         hold_clks <= 0;
      end else begin
         bclk_q <= rx_bit_clk;
         sm_q <= sync_match;
         if (sync_match && !sm_q) begin
            match_count <= match_count + 1;
            run <= (rx_bit_clk && !bclk_q) ? 1 : 0;
         end else if (sync_match && rx_bit_clk && !bclk_q) begin
            run <= run + 1;
         end
         if (!sync_match && sm_q) begin
            hold_clks <= run;
         end
      end
   end
endmodule : fsd_host_model
`default_nettype wire

//--- fsk_demod_sync_detect_tb_top.sv
// Purpose: Self-checking bench for the demodulator and sync word matcher
// Assumes: Positive tone rotation carries a one; zero wait APB slave
// Notes: Bit period 128 clocks (126 in scenario 5), demod tick every 2, oversample strobe every 4
`timescale 1ns/1ps
`default_nettype none
module fsk_demod_sync_detect_tb_top;
   import fsd_pkg::*;
   localparam logic [23:0] WORD = 24'h3a5c96;
   logic clk, rst_n, demod_tick, recovery_oversample_clock, cur_bit;
   logic rx_data, rx_bit_clk, sync_match, irq, err;
   fsd_apb_req_t apb_req;
   fsd_apb_rsp_t apb_rsp;
   fsd_iq_t iq;
   logic [1:0] ph;
   logic [7:0] cyc;
   logic [31:0] rd;
   int bad_count, n_checks, ticks, match_count, hold_clks, m0, bp;
   // Scenario table: mode, select, length, tolerance, error mask, match expected
   logic [2:0] t_mode [6] = '{3'h2, 3'h3, 3'h2, 3'h2, 3'h0, 3'h2};
   logic [1:0] t_sel [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0};
   logic [1:0] t_len [6] = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h0, 2'h2};
   logic [1:0] t_tol [6] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h1};
   logic [23:0] t_err [6] = '{24'h0, 24'h0, 24'h000400, 24'h00a010, 24'h0, 24'h000800};
   logic t_exp [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

   fsd_top i_dut (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .iq(iq),
      .demod_tick(demod_tick), .recovery_oversample_clock(recovery_oversample_clock),
      .rx_data(rx_data), .rx_bit_clk(rx_bit_clk), .sync_match(sync_match), .irq(irq));
   fsd_host_model i_host (.clk(clk), .rst_n(rst_n), .rx_bit_clk(rx_bit_clk),
      .sync_match(sync_match), .match_count(match_count), .hold_clks(hold_clks));

   // Clock
   always #5 clk = ~clk;

   // Strobes, limited quadrature tone source and run limit
   always @(posedge clk) begin
      cyc <= cyc + 8'h01;
      demod_tick <= cyc[0];
      recovery_oversample_clock <= (cyc[1:0] == 2'h3);
      if (demod_tick) begin
         ph <= cur_bit ? ph + 2'h1 : ph - 2'h1;
      end
      iq <= '{i: ~(ph[0] ^ ph[1]), q: ~ph[1]};
      ticks++;
      if (ticks == 80000) begin
         bad_count++;
         results();
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; read data and error taken at the completing edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      @(posedge clk);
      while (apb_rsp.pready !== 1'b1) @(posedge clk);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge clk);
   endtask : apb

   // Transmit n bits, most significant first
   task automatic send(input logic [23:0] w, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         cur_bit <= w[k];
         repeat (bp) @(posedge clk);
      end
   endtask : send

   // Verdict
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      apb_req = '0;
      iq = '0;
      {demod_tick, recovery_oversample_clock, cur_bit, ph, cyc} = '0;
      {bad_count, n_checks, ticks, bp} = {32'd0, 32'd0, 32'd0, 32'd128};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, FSD_OFS_DEMOD, 32'h0);
      chk(rd, FSD_RST_DEMOD);
      apb(1'b0, FSD_OFS_SYNC, 32'h0);
      chk(rd, FSD_RST_SYNC);
      apb(1'b0, FSD_OFS_BW, 32'h0);
      chk(rd, FSD_RST_BW);
      apb(1'b0, 8'h40, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, FSD_OFS_BW, 32'h1 << FSD_DBW_LSB);
      apb(1'b0, FSD_OFS_BW, 32'h0);
      chk(rd, 32'h10);
      apb(1'b1, FSD_OFS_IEN, 32'h1);
      $display("test registers done");
      for (int s = 0; s < 6; s++) begin
         bp = (s == 5) ? 126 : 128;
         apb(1'b1, FSD_OFS_DEMOD, {6'h00, t_mode[s], 7'h00, 10'h04b, t_sel[s], 4'h0});
         apb(1'b1, FSD_OFS_SYNC, {WORD, t_tol[s], t_len[s], 4'h0});
         m0 = match_count;
         send(24'h00aaaa, 16);
         send(WORD ^ t_err[s], 12 + 4 * t_len[s]);
         send(24'h0, 12);
         chk(32'(match_count != m0), 32'(t_exp[s]));
         chk(rx_data, 1'b0);
         apb(1'b0, FSD_OFS_STAT, 32'h0);
         chk(rd[FSD_IRQ_MATCH], t_exp[s]);
         chk(irq, t_exp[s]);
         if (t_exp[s]) chk(hold_clks, 32'd9);
         if (s == 0) begin
            apb(1'b1, FSD_OFS_IEN, 32'h0);
            chk(irq, 1'b0);
            apb(1'b1, FSD_OFS_IEN, 32'h1);
         end
         apb(1'b1, FSD_OFS_ICLR, 32'h3);
         apb(1'b0, FSD_OFS_STAT, 32'h0);
         chk(rd[FSD_IRQ_MATCH], 1'b0);
         chk(irq, 1'b0);
         $display("test %0d done", s);
      end
      results();
   end
endmodule : fsk_demod_sync_detect_tb_top
`default_nettype wire
